// ---- core/interrupt_priority_enable.sv ----
// Purpose: enable/priority registers and priority encoder for three request groups
// Assumes: request inputs are one-cycle pulses synchronous to mclk
// Notes:   slave answers with zero wait states; hresp always OKAY
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps

module interrupt_priority_enable (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  request_group0,
	input  wire logic [7:0]  request_group1,
	input  wire logic [7:0]  request_group2,
	input  wire logic        core_ack,
	output logic             core_irq,
	output logic      [4:0]  core_source,
	output logic      [1:0]  core_level,
	output logic             irq
);
	import intprio_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0]  en_hi_r   [GROUPS];
	logic [7:0]  en_lo_r   [GROUPS];
	logic [7:0]  req_r     [GROUPS];
	logic [7:0]  mask_r    [GROUPS];
	logic [7:0]  req_in    [GROUPS];
	logic [7:0]  src_ok    [GROUPS];
	logic [7:0]  lo_wmask  [GROUPS];
	logic [7:0]  hi_wmask  [GROUPS];
	logic [7:0]  rd_clr    [GROUPS];
	logic [7:0]  ack_clr   [GROUPS];
	logic        gie_r;
	logic        wr_pend_r;
	logic [11:0] wr_idx_r;
	logic [11:0] a_idx;
	logic        a_valid;
	logic        a_mapped;
	logic [7:0]  wdat;
	logic [7:0]  rd_nxt;
	logic        best_vld;
	logic [1:0]  best_lvl;
	logic [4:0]  best_src;
	logic        any_masked;

	assign req_in[0]   = request_group0;
	assign req_in[1]   = request_group1;
	assign req_in[2]   = request_group2;
	assign src_ok[0]   = GROUP0_SOURCES;
	assign src_ok[1]   = GROUP1_SOURCES;
	assign src_ok[2]   = GROUP2_SOURCES;
	assign hi_wmask[0] = GROUP0_HIGH_WMASK;
	assign hi_wmask[1] = 8'hff;
	assign hi_wmask[2] = 8'hff;
	assign lo_wmask[0] = GROUP0_LOW_WMASK;
	assign lo_wmask[1] = 8'hff;
	assign lo_wmask[2] = 8'hff;
	assign wdat        = hwdata[7:0];

	// ------------------------------------------------------------
	// ahb-lite address phase
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign a_valid   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign a_idx     = haddr[13:2];
	assign a_mapped  = (haddr[31:14] == 18'h0) && (haddr[1:0] == 2'h0);

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= a_valid && hwrite && a_mapped;
		end
	end

	// index of the write whose data arrives in the next cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_idx_r <= 12'h000;
		end else begin
			wr_idx_r <= a_idx;
		end
	end

	// ------------------------------------------------------------
	// enable, mask and control registers (write in data phase)
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int g = 0; g < GROUPS; g++) begin
				en_hi_r[g] <= ENABLE_RESET;
			end
		end else if (wr_pend_r) begin
			if (wr_idx_r == GROUP0_ENABLE_HIGH_IDX) begin
				en_hi_r[0] <= wdat & hi_wmask[0];
			end else if (wr_idx_r == GROUP1_ENABLE_HIGH_IDX) begin
				en_hi_r[1] <= wdat & hi_wmask[1];
			end else if (wr_idx_r == GROUP2_ENABLE_HIGH_IDX) begin
				en_hi_r[2] <= wdat & hi_wmask[2];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int g = 0; g < GROUPS; g++) begin
				en_lo_r[g] <= ENABLE_RESET;
			end
		end else if (wr_pend_r) begin
			if (wr_idx_r == GROUP0_ENABLE_LOW_IDX) begin
				en_lo_r[0] <= wdat & lo_wmask[0];
			end else if (wr_idx_r == GROUP1_ENABLE_LOW_IDX) begin
				en_lo_r[1] <= wdat & lo_wmask[1];
			end else if (wr_idx_r == GROUP2_ENABLE_LOW_IDX) begin
				en_lo_r[2] <= wdat & lo_wmask[2];
			end
		end
	end

	// masks keep only the bits that have a request source behind them
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int g = 0; g < GROUPS; g++) begin
				mask_r[g] <= ENABLE_RESET;
			end
		end else if (wr_pend_r) begin
			if (wr_idx_r == MASK_GROUP0_IDX) begin
				mask_r[0] <= wdat & src_ok[0];
			end else if (wr_idx_r == MASK_GROUP1_IDX) begin
				mask_r[1] <= wdat & src_ok[1];
			end else if (wr_idx_r == MASK_GROUP2_IDX) begin
				mask_r[2] <= wdat & src_ok[2];
			end
		end
	end

	// global enable: a register write wins over a core acknowledge
	always_ff @(posedge mclk) begin
		if (rst) begin
			gie_r <= 1'b0;
		end else if (wr_pend_r && wr_idx_r == CONTROL_IDX) begin
			gie_r <= wdat[GLOBAL_ENABLE_BIT];
		end else if (core_ack) begin
			gie_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// request bits: set wins over read-clear and acknowledge
	// ------------------------------------------------------------
	always_comb begin
		for (int g = 0; g < GROUPS; g++) begin
			rd_clr[g] = 8'h00;
		end
		if (a_valid && !hwrite && a_mapped) begin
			if (a_idx == REQUEST_GROUP0_IDX) begin
				rd_clr[0] = 8'hff;
			end else if (a_idx == REQUEST_GROUP1_IDX) begin
				rd_clr[1] = 8'hff;
			end else if (a_idx == REQUEST_GROUP2_IDX) begin
				rd_clr[2] = 8'hff;
			end
		end
	end

	// only the presented source is cleared; a number beyond the groups clears nothing
	always_comb begin
		for (int g = 0; g < GROUPS; g++) begin
			ack_clr[g] = 8'h00;
			if (core_ack && core_irq && core_source[4:3] == 2'(g)) begin
				ack_clr[g][core_source[2:0]] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int g = 0; g < GROUPS; g++) begin
				req_r[g] <= 8'h00;
			end
		end else begin
			for (int g = 0; g < GROUPS; g++) begin
				req_r[g] <= (req_r[g] & ~rd_clr[g] & ~ack_clr[g])
					| (req_in[g] & src_ok[g]);
			end
		end
	end

	// ------------------------------------------------------------
	// read data, registered in the address phase
	// ------------------------------------------------------------
	// a read right after a write to the same register still sees the old value
	always_comb begin
		rd_nxt = 8'h00;
		if (a_idx == REQUEST_GROUP0_IDX) begin
			rd_nxt = req_r[0];
		end else if (a_idx == GROUP0_ENABLE_HIGH_IDX) begin
			rd_nxt = en_hi_r[0];
		end else if (a_idx == GROUP0_ENABLE_LOW_IDX) begin
			rd_nxt = en_lo_r[0] & lo_wmask[0];
		end else if (a_idx == REQUEST_GROUP1_IDX) begin
			rd_nxt = req_r[1];
		end else if (a_idx == GROUP1_ENABLE_HIGH_IDX) begin
			rd_nxt = en_hi_r[1];
		end else if (a_idx == GROUP1_ENABLE_LOW_IDX) begin
			rd_nxt = en_lo_r[1];
		end else if (a_idx == REQUEST_GROUP2_IDX) begin
			rd_nxt = req_r[2];
		end else if (a_idx == GROUP2_ENABLE_HIGH_IDX) begin
			rd_nxt = en_hi_r[2];
		end else if (a_idx == GROUP2_ENABLE_LOW_IDX) begin
			rd_nxt = en_lo_r[2];
		end else if (a_idx == CONTROL_IDX) begin
			rd_nxt = {gie_r, 7'h00};
		end else if (a_idx == MASK_GROUP0_IDX) begin
			rd_nxt = mask_r[0];
		end else if (a_idx == MASK_GROUP1_IDX) begin
			rd_nxt = mask_r[1];
		end else if (a_idx == MASK_GROUP2_IDX) begin
			rd_nxt = mask_r[2];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hrdata <= 32'h0;
		end else if (a_valid && !hwrite) begin
			hrdata <= a_mapped ? {24'h0, rd_nxt} : 32'h0;
		end
	end

	// ------------------------------------------------------------
	// priority encoder
	// ------------------------------------------------------------
	// strict compare keeps the first hit on a tie: lowest group, then lowest bit
	always_comb begin
		logic [1:0] lvl;
		lvl      = LEVEL_DISABLED;
		best_vld = 1'b0;
		best_lvl = LEVEL_DISABLED;
		best_src = 5'h00;
		for (int g = 0; g < GROUPS; g++) begin
			for (int b = 0; b < 8; b++) begin
				lvl = {en_hi_r[g][b], en_lo_r[g][b]};
				if (req_r[g][b] && lvl != LEVEL_DISABLED && lvl > best_lvl) begin
					best_vld = 1'b1;
					best_lvl = lvl;
					best_src = 5'(g * 8 + b);
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			core_irq <= 1'b0;
		end else begin
			core_irq <= best_vld && gie_r && !core_ack;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			core_source <= 5'h00;
			core_level  <= LEVEL_DISABLED;
		end else begin
			core_source <= best_src;
			core_level  <= best_lvl;
		end
	end

	// ------------------------------------------------------------
	// summary interrupt: any masked-in request bit
	// ------------------------------------------------------------
	always_comb begin
		any_masked = 1'b0;
		for (int g = 0; g < GROUPS; g++) begin
			any_masked = any_masked | (|(req_r[g] & mask_r[g]));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= any_masked;
		end
	end
endmodule : interrupt_priority_enable

// ---- core/intprio_pkg.sv ----
// Purpose: constants for the priority-encoded interrupt enable block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   byte address of a register is four times its index
package intprio_pkg;
	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [11:0] REQUEST_GROUP0_IDX     = 12'hfc0;
	localparam logic [11:0] GROUP0_ENABLE_HIGH_IDX = 12'hfc1;
	localparam logic [11:0] GROUP0_ENABLE_LOW_IDX  = 12'hfc2;
	localparam logic [11:0] REQUEST_GROUP1_IDX     = 12'hfc3;
	localparam logic [11:0] GROUP1_ENABLE_HIGH_IDX = 12'hfc4;
	localparam logic [11:0] GROUP1_ENABLE_LOW_IDX  = 12'hfc5;
	localparam logic [11:0] REQUEST_GROUP2_IDX     = 12'hfc6;
	localparam logic [11:0] GROUP2_ENABLE_HIGH_IDX = 12'hfc7;
	localparam logic [11:0] GROUP2_ENABLE_LOW_IDX  = 12'hfc8;
	localparam logic [11:0] CONTROL_IDX            = 12'hfcf;
	localparam logic [11:0] MASK_GROUP0_IDX        = 12'hfd0;
	localparam logic [11:0] MASK_GROUP1_IDX        = 12'hfd1;
	localparam logic [11:0] MASK_GROUP2_IDX        = 12'hfd2;
	// ------------------------------------------------------------
	// field layouts and reset values
	// ------------------------------------------------------------
	localparam int          GROUPS               = 3;
	localparam int          GLOBAL_ENABLE_BIT    = 7;
	localparam logic [7:0]  GROUP0_SOURCES       = 8'h79;
	localparam logic [7:0]  GROUP1_SOURCES       = 8'hff;
	localparam logic [7:0]  GROUP2_SOURCES       = 8'h0f;
	localparam logic [7:0]  GROUP0_HIGH_WMASK    = 8'hff;
	localparam logic [7:0]  GROUP0_LOW_WMASK     = 8'h79;
	localparam logic [7:0]  ENABLE_RESET         = 8'h00;
	localparam logic [1:0]  LEVEL_DISABLED       = 2'h0;
	localparam logic [1:0]  HTRANS_NONSEQ        = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ           = 2'h3;
endpackage : intprio_pkg

// ---- verif/core_model.sv ----
// Purpose: core stand-in acknowledging presented requests
// Assumes: dly sets acknowledge latency in cycles
// Notes:   records source and level presented
`timescale 1ns/1ps
module core_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       core_irq,
	input  wire logic [4:0] core_source,
	input  wire logic [1:0] core_level,
	input  wire logic [2:0] dly,
	output logic            core_ack,
	output logic      [4:0] got_src,
	output logic      [1:0] got_lvl,
	output int              n_ack
);
	logic [2:0] cnt_r;
	always_ff @(posedge mclk) begin
		core_ack <= 1'b0;
		if (rst) begin
			cnt_r <= 3'h0;
			n_ack <= 0;
		end else if (core_irq && !core_ack) begin
			cnt_r <= cnt_r + 3'h1;
			if (cnt_r == dly) begin
				core_ack <= 1'b1;
				got_src  <= core_source;
				got_lvl  <= core_level;
				n_ack    <= n_ack + 1;
				cnt_r    <= 3'h0;
			end
		end else begin
			cnt_r <= 3'h0;
		end
	end
endmodule : core_model

// ---- verif/interrupt_priority_enable_tb_top.sv ----
// Purpose: random and corner tests of the interrupt enable block
// Assumes: zero-wait slave, core model acks presented requests
// Notes:   expectations come from enable pairs and source masks
`timescale 1ns/1ps
module interrupt_priority_enable_tb_top;
	import intprio_pkg::*;
	logic        mclk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic        core_ack, core_irq, irq, x;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0]  htrans = 0, core_level, got_lvl;
	logic [4:0]  core_source, got_src;
	logic [2:0]  dly = 0;
	logic [7:0]  rq [3] = '{default: 8'h0};
	logic [7:0]  eh [3], el [3], mk [3], rv [3], e;
	int          err_total = 0, n_compared = 0, cyc = 0, n_ack, k;
	localparam logic [7:0] SRC [3] = '{GROUP0_SOURCES, GROUP1_SOURCES, GROUP2_SOURCES};
	localparam logic [11:0] EH [3] = '{GROUP0_ENABLE_HIGH_IDX, GROUP1_ENABLE_HIGH_IDX,
		GROUP2_ENABLE_HIGH_IDX};
	localparam logic [11:0] EL [3] = '{GROUP0_ENABLE_LOW_IDX, GROUP1_ENABLE_LOW_IDX,
		GROUP2_ENABLE_LOW_IDX};
	localparam logic [11:0] RQ [3] = '{REQUEST_GROUP0_IDX, REQUEST_GROUP1_IDX, REQUEST_GROUP2_IDX};
	localparam logic [11:0] MK [3] = '{MASK_GROUP0_IDX, MASK_GROUP1_IDX, MASK_GROUP2_IDX};
	initial forever #20 mclk = ~mclk;
	interrupt_priority_enable i_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.request_group0(rq[0]), .request_group1(rq[1]), .request_group2(rq[2]),
		.core_ack, .core_irq, .core_source, .core_level, .irq);
	core_model i_core (.mclk, .rst, .core_irq, .core_source, .core_level, .dly,
		.core_ack, .got_src, .got_lvl, .n_ack);
	task close_out;
		$display("errors %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one AHB single word transfer; read data lands in q
	task bus(input logic [11:0] idx, input logic w, input logic [7:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {18'h0, idx, 2'h0};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	// {found, level, source}: highest level, lowest source on ties
	function automatic logic [7:0] best();
		logic [7:0] b = 8'h0;
		logic [1:0] l;
		for (int g = 0; g < 3; g++) for (int i = 0; i < 8; i++) begin
			l = {eh[g][i], el[g][i]};
			if (rv[g][i] && SRC[g][i] && l > b[6:5]) b = {1'b1, l, 5'(g * 8 + i)};
		end
		return b;
	endfunction : best
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		void'($urandom(32'h745debe0));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		for (int g = 0; g < 3; g++) begin
			bus(EL[g], 1'b0, 8'h0);
			chk("low reset", q, 32'h0);
		end
		bus(EL[0], 1'b1, 8'hff);
		bus(EL[0], 1'b0, 8'h0);
		chk("group0 low", q, {24'h0, GROUP0_LOW_WMASK});
		bus(12'h0, 1'b1, 8'h5a);
		bus(12'h0, 1'b0, 8'h0);
		chk("unmapped", q, 32'h0);
		bus(RQ[0], 1'b1, 8'hff);
		bus(RQ[0], 1'b0, 8'h0);
		chk("request write", q, 32'h0);
		rq[1] <= 8'ha5;
		bus(RQ[1], 1'b0, 8'h0);
		rq[1] <= 8'h0;
		chk("set over clear", q, {24'h0, 8'ha5 & GROUP1_SOURCES});
		bus(RQ[1], 1'b0, 8'h0);
		chk("request held", q, {24'h0, 8'ha5 & GROUP1_SOURCES});
		bus(RQ[1], 1'b0, 8'h0);
		chk("request cleared", q, 32'h0);
		for (int t = 0; t < 12; t++) begin
			dly <= t[0] ? 3'd3 : 3'd0;
			x = 1'b0;
			for (int g = 0; g < 3; g++) begin
				eh[g] = (t < 2) ? SRC[g] : 8'($urandom) & SRC[g];
				el[g] = (t < 2) ? SRC[g] : 8'($urandom) & SRC[g];
				mk[g] = 8'($urandom) & SRC[g];
				bus(EH[g], 1'b1, eh[g]);
				bus(EL[g], 1'b1, el[g]);
				bus(MK[g], 1'b1, mk[g]);
				bus(EL[g], 1'b0, 8'h0);
				chk("enable low", q, {24'h0, el[g]});
			end
			@(posedge mclk);
			for (int g = 0; g < 3; g++) begin
				rv[g] = 8'($urandom);
				rq[g] <= rv[g];
				x = x | (|(rv[g] & SRC[g] & mk[g]));
			end
			@(posedge mclk);
			for (int g = 0; g < 3; g++) rq[g] <= 8'h0;
			repeat (2) @(negedge mclk);
			chk("irq", irq, x);
			chk("polled", core_irq, 1'b0);
			e = best();
			k = n_ack;
			bus(CONTROL_IDX, 1'b1, 8'h80);
			for (int w = 0; w < 12 && n_ack == k; w++) @(posedge mclk);
			chk("acks", n_ack - k, e[7]);
			if (e[7]) begin
				chk("source", got_src, e[4:0]);
				chk("level", got_lvl, e[6:5]);
				rv[e[4:3]][e[2:0]] = 1'b0;
			end
			bus(CONTROL_IDX, 1'b1, 8'h0);
			for (int g = 0; g < 3; g++) begin
				bus(RQ[g], 1'b0, 8'h0);
				chk("request", q, {24'h0, rv[g] & SRC[g]});
			end
			@(negedge mclk);
			chk("irq cleared", irq, 1'b0);
		end
		close_out();
	end
endmodule : interrupt_priority_enable_tb_top

// ---- verif/intprio_sva.sv ----
// Purpose: port checker for the interrupt enable block
// Assumes: one clock domain, synchronous reset
// Notes:   bound to the design below
`timescale 1ns/1ps
module intprio_sva import intprio_pkg::*; (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic [7:0]  request_group1,
	input wire logic        core_ack,
	input wire logic        core_irq,
	input wire logic [4:0]  core_source,
	input wire logic [1:0]  core_level,
	input wire logic        irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic rd;
	assign rd = hsel && hready && htrans[1] && !hwrite;
	property p_lvl; core_irq |-> core_level != LEVEL_DISABLED; endproperty
	a_lvl: assert property (p_lvl) else $error("level off");
	property p_g0s; core_irq |-> !(core_source inside {5'd1, 5'd2, 5'd7}); endproperty
	a_g0s: assert property (p_g0s) else $error("reserved source");
	property p_g2s; core_irq |-> core_source < 5'd20; endproperty
	a_g2s: assert property (p_g2s) else $error("source range");
	property p_g0r; rd && haddr == {18'h0, GROUP0_ENABLE_LOW_IDX, 2'h0}
		|=> (hrdata & 32'hffffff86) == 32'h0; endproperty
	a_g0r: assert property (p_g0r) else $error("reserved bits read");
	property p_g2r; rd && haddr == {18'h0, REQUEST_GROUP2_IDX, 2'h0}
		|=> hrdata[7:4] == 4'h0; endproperty
	a_g2r: assert property (p_g2r) else $error("group2 upper");
	property p_req; (request_group1 != 8'h0) ##1 (rd && haddr == {18'h0, REQUEST_GROUP1_IDX, 2'h0})
		|=> (hrdata[7:0] & $past(request_group1, 2)) == $past(request_group1, 2); endproperty
	a_req: assert property (p_req) else $error("request lost");
	property p_ack; core_ack |=> !core_irq; endproperty
	a_ack: assert property (p_ack) else $error("irq after ack");
	property p_hold; core_ack |=> (!core_irq) [*2]; endproperty
	a_hold: assert property (p_hold) else $error("enable not cleared");
	c_irq: cover property ($rose(core_irq));
	c_ack: cover property (core_ack);
	c_msk: cover property ($rose(irq));
endmodule : intprio_sva
bind interrupt_priority_enable intprio_sva i_sva (.*);
